// ===== sfrl_top.sv
// Purpose: fault routing, overcurrent policy and default output resolution
// Assumes: field inputs are asynchronous; config written by software port
// Notes:   supply power-cycle is seen as field_supply_ok falling
`timescale 1ns/1ps
module sfrl_top
  import sfrl_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Register port
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [31:0]        rdata,
  // Field side
  input  wire logic               field_supply_ok,
  input  wire logic [NUM_CH-1:0]  overcurrent_in,
  input  wire logic [NUM_CH-1:0]  oc_present,
  input  wire logic [CUR_W-1:0]   ai_cur [NUM_AI],
  input  wire logic               ai_triple,
  // State machine side
  input  wire logic [NUM_SIG-1:0] simple_assign,
  input  wire logic [NUM_SIG-1:0] simple_value,
  input  wire logic               in_compound,
  input  wire logic               compound_enter,
  // Outputs
  output logic [NUM_SIG-1:0]      sig_out,
  output logic [NUM_CH-1:0]       channel_overload_fault,
  output logic                    redundancy_mismatch_fault,
  output logic                    redundancy_mismatch_warning,
  output logic [NUM_FAULT-1:0]    transition_faults,
  output logic                    failsafe
);
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic               run;
  logic               disc_is_warn;
  logic [CUR_W-1:0]   disc_cur;
  logic [CNT_W-1:0]   disc_time;
  logic [CNT_W-1:0]   recov_time;
  logic [2*NUM_CH-1:0] policy;
  logic [NUM_FAULT-1:0] fs_sel;
  logic [NUM_SIG-1:0] def_top;
  logic [NUM_SIG-1:0] def_cmp;
  logic [NUM_SIG-1:0] cmp_latched;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      run          <= 1'b0;
      disc_is_warn <= 1'b0;
      disc_cur     <= DISC_CUR_RST;
      disc_time    <= DISC_TIME_RST;
      recov_time   <= RECOV_RST;
      policy       <= '0;
      fs_sel       <= '0;
      def_top      <= '0;
      def_cmp      <= '0;
    end
    else if (wr)
    begin
      case (addr)
        REG_CTRL:
        begin
          run          <= wdata[CTRL_RUN_BIT];
          disc_is_warn <= wdata[CTRL_TRIP_BIT];
        end
        REG_DISC_CUR:  disc_cur   <= wdata[CUR_W-1:0];
        REG_DISC_TIME: disc_time  <= wdata[CNT_W-1:0];
        REG_RECOV:     recov_time <= wdata[CNT_W-1:0];
        REG_POLICY:    policy     <= wdata[2*NUM_CH-1:0];
        REG_FSSEL:     fs_sel     <= wdata[NUM_FAULT-1:0];
        REG_DEF_TOP:   def_top    <= wdata[NUM_SIG-1:0];
        REG_DEF_CMP:   def_cmp    <= wdata[NUM_SIG-1:0];
        default:       ;
      endcase
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [NUM_CH-1:0] oc_s1, oc_s2, pr_s1, pr_s2;
  logic              sup_s1, sup_s2, sup_d;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      oc_s1  <= '0;
      oc_s2  <= '0;
      pr_s1  <= '0;
      pr_s2  <= '0;
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
      sup_d  <= 1'b0;
    end
    else
    begin
      oc_s1  <= overcurrent_in;
      oc_s2  <= oc_s1;
      pr_s1  <= oc_present;
      pr_s2  <= pr_s1;
      sup_s1 <= field_supply_ok;
      sup_s2 <= sup_s1;
      sup_d  <= sup_s2;
    end
  end
  // A supply power-cycle shows as a falling edge of the supply-good level
  wire supply_cycle = sup_d & ~sup_s2;

  // ----------------------------------------
  // Redundant analog mismatch check
  // ----------------------------------------
  function automatic logic [CUR_W-1:0] absdiff(input logic [CUR_W-1:0] a,
                                               input logic [CUR_W-1:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction
  wire mis01 = absdiff(ai_cur[0], ai_cur[1]) > disc_cur;
  wire mis02 = absdiff(ai_cur[0], ai_cur[2]) > disc_cur;
  wire mis12 = absdiff(ai_cur[1], ai_cur[2]) > disc_cur;
  wire mismatch = mis01 | (ai_triple & (mis02 | mis12));
  logic [CNT_W-1:0] disc_cnt;
  logic             disc_hit;
  always_ff @(posedge sys_clk)
  begin
    if (rst | ~mismatch)
    begin
      disc_cnt <= '0;
      disc_hit <= 1'b0;
    end
    else if (disc_cnt >= disc_time) //R01
      disc_hit <= 1'b1;
    else
      disc_cnt <= disc_cnt + 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      redundancy_mismatch_fault   <= 1'b0;
      redundancy_mismatch_warning <= 1'b0;
    end
    else
    begin
      redundancy_mismatch_fault   <= disc_hit & ~disc_is_warn; //R02
      redundancy_mismatch_warning <= disc_hit & disc_is_warn;  //R02
    end
  end

  // ----------------------------------------
  // Overcurrent policy per channel
  // ----------------------------------------
  sfrl_oc_t         oc_st [NUM_CH];
  logic [CNT_W-1:0] rec_cnt [NUM_CH];
  logic [NUM_CH-1:0] oc_fs_trip;
  logic [NUM_CH-1:0] ch_fault;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : oc_gen
      wire [1:0] pol = policy[2*g+1:2*g];
      assign ch_fault[g]   = oc_st[g] != OC_OK; //R08 R09
      assign oc_fs_trip[g] = ch_fault[g] & (pol == POL_FAILSAFE); //R10
      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          oc_st[g]   <= OC_OK;
          rec_cnt[g] <= '0;
        end
        else
        begin
          case (oc_st[g])
            OC_OK:
              if (oc_s2[g]) //R08
              begin
                oc_st[g]   <= (pol == POL_AUTO) ? OC_OFF : OC_HLD;
                rec_cnt[g] <= '0;
              end
            OC_OFF:
              if (rec_cnt[g] >= recov_time) //R11
                oc_st[g] <= pr_s2[g] ? OC_OFF : OC_OK; //R12
              else
                rec_cnt[g] <= rec_cnt[g] + 1'b1;
            OC_HLD:
              if (supply_cycle) //R13
                oc_st[g] <= OC_OK;
            default: oc_st[g] <= OC_OK;
          endcase
          if (oc_st[g] == OC_OFF && rec_cnt[g] >= recov_time && pr_s2[g])
            rec_cnt[g] <= '0; //R12
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Fault routing and fail-safe
  // ----------------------------------------
  wire [NUM_FAULT-1:0] all_faults = {redundancy_mismatch_warning,
                                     redundancy_mismatch_fault, ch_fault};
  wire [NUM_FAULT-1:0] fs_mask = {fs_sel[NUM_FAULT-1:NUM_CH], {NUM_CH{1'b0}}};
  // A latched failsafe-policy overload is released by the same supply cycle
  // that clears fail-safe, so it must not re-arm fail-safe in that cycle
  wire fs_cause = |(all_faults & fs_mask) | ((|oc_fs_trip) & ~supply_cycle); //R05 R10
  // Failsafe-policy overcurrent is hidden just like a checked failsafe box
  wire [NUM_CH-1:0] oc_hidden;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : hide_gen
      assign oc_hidden[g] = policy[2*g+1:2*g] == POL_FAILSAFE;
    end
  endgenerate
  wire [NUM_FAULT-1:0] hidden = fs_mask | {2'b00, oc_hidden};
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      failsafe <= 1'b0;
    else if (fs_cause)
      failsafe <= 1'b1; //R05
    else if (supply_cycle)
      failsafe <= 1'b0; //R10
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      transition_faults      <= '0;
      channel_overload_fault <= '0;
    end
    else
    begin
      transition_faults      <= all_faults & ~hidden; //R06 R13
      channel_overload_fault <= ch_fault; //R09
    end
  end

  // ----------------------------------------
  // Default value resolution
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cmp_latched <= '0;
    else if (compound_enter)
      cmp_latched <= def_cmp; //R17
  end
  wire [NUM_SIG-1:0] outer = in_compound ? cmp_latched : def_top; //R16 R18
  wire [NUM_SIG-1:0] resolved = (simple_assign & simple_value) |
                                (~simple_assign & outer); //R19
  // Channels follow signal lanes 0..NUM_CH-1; the rest are variables
  wire [NUM_SIG-1:0] chan_off = {{(NUM_SIG-NUM_CH){1'b0}}, ch_fault};
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      sig_out <= '0;
    else if (failsafe)
      sig_out <= '0; //R20
    else if (!run)
      sig_out <= def_top & ~chan_off; //R15
    else
      sig_out <= resolved & ~chan_off; //R08
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire [31:0] rd_mux =
    (addr == REG_CTRL)      ? {30'h0, disc_is_warn, run} :
    (addr == REG_DISC_CUR)  ? {16'h0, disc_cur} :
    (addr == REG_DISC_TIME) ? {8'h0, disc_time} :
    (addr == REG_RECOV)     ? {8'h0, recov_time} :
    (addr == REG_POLICY)    ? {16'h0, policy} :
    (addr == REG_FSSEL)     ? {22'h0, fs_sel} :
    (addr == REG_DEF_TOP)   ? {16'h0, def_top} :
    (addr == REG_DEF_CMP)   ? {16'h0, def_cmp} :
    (addr == REG_STATUS)    ? {31'h0, failsafe} :
    (addr == REG_FAULTS)    ? {22'h0, all_faults} : 32'h0;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata <= '0;
    else
      rdata <= rd ? rd_mux : 32'h0;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  mis_short_a: assert property (@(posedge sys_clk) disable iff (rst) //R01
    !mismatch |=> !disc_hit)
    else $error("mismatch reported without persistence");
  fs_enter_a: assert property (@(posedge sys_clk) disable iff (rst) //R05
    fs_cause |=> failsafe)
    else $error("fail-safe not entered");
  fs_outs_a: assert property (@(posedge sys_clk) disable iff (rst) //R20
    failsafe |=> sig_out == '0)
    else $error("outputs live in fail-safe");
  hide_fs_a: assert property (@(posedge sys_clk) disable iff (rst) //R06
    ##1 (transition_faults & $past(hidden)) == '0)
    else $error("hidden fault visible");
  oc_off_a: assert property (@(posedge sys_clk) disable iff (rst) //R08
    ch_fault[0] && !failsafe |=> !sig_out[0])
    else $error("channel energized during overcurrent");
  warn_sel_a: assert property (@(posedge sys_clk) disable iff (rst) //R02
    disc_hit && disc_is_warn |=> redundancy_mismatch_warning && !redundancy_mismatch_fault)
    else $error("warning routing wrong");
  hold_none_a: assert property (@(posedge sys_clk) disable iff (rst) //R13
    oc_st[0] == OC_HLD && !supply_cycle |=> oc_st[0] == OC_HLD)
    else $error("no-recover released early");
  start_def_a: assert property (@(posedge sys_clk) disable iff (rst) //R15
    !run && !failsafe && !ch_fault[0] |=> sig_out[0] == $past(def_top[0]))
    else $error("default not driven before run");
endmodule

// ===== sfrl_pkg.sv
// Purpose: constants for the safety fault response logic
// Assumes: 250 MHz sys_clk, synchronous active-high reset
// Notes:   configuration arrives on a plain register port
//
// What this block does
// R01: Mismatch counts only after discrepancy time persists
// R02: Dual/triple mismatch reports fault or warning
// R03: Configured mismatch current must exceed zero
// R04: Mismatch current should be well below span
// R05: Failsafe-selected active fault enters fail-safe
// R06: Failsafe-selected faults hidden from transition inputs
// R07: Every fault routed to failsafe or transitions
// R08: Overcurrent de-energizes channel and raises fault
// R09: Overcurrent fault per output and pulsed input
// R10: Failsafe policy latches until field supply cycles
// R11: Auto-recover clears fault after recovery time
// R12: Auto-recover repeats while overcurrent persists
// R13: No-recover holds off until supply cycles
// R14: Every output and variable needs a default
// R15: Start of execution drives all defaults
// R16: Unassigned outputs take top-level defaults
// R17: Entering compound state applies its defaults
// R18: Compound defaults fill unassigned simple outputs
// R19: Innermost assigning state wins
// R20: Fail-safe forces safety outputs de-energized
package sfrl_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_AI    = 3;
  localparam int NUM_CH    = 8;
  localparam int NUM_SIG   = 16;
  localparam int CUR_W     = 16;
  localparam int CNT_W     = 24;
  localparam int NUM_FAULT = NUM_CH + 2;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_DISC_CUR  = 8'h04;
  localparam logic [7:0] REG_DISC_TIME = 8'h08;
  localparam logic [7:0] REG_RECOV     = 8'h0C;
  localparam logic [7:0] REG_POLICY    = 8'h10;
  localparam logic [7:0] REG_FSSEL     = 8'h14;
  localparam logic [7:0] REG_DEF_TOP   = 8'h18;
  localparam logic [7:0] REG_DEF_CMP   = 8'h1C;
  localparam logic [7:0] REG_STATUS    = 8'h20;
  localparam logic [7:0] REG_FAULTS    = 8'h24;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_TRIP_BIT = 1;
  localparam int FSSEL_DISC_BIT = NUM_CH;
  localparam int FSSEL_WARN_BIT = NUM_CH + 1;
  localparam logic [CUR_W-1:0] DISC_CUR_RST  = 16'h0010;
  localparam logic [CNT_W-1:0] DISC_TIME_RST = 24'h0003E8;
  localparam logic [CNT_W-1:0] RECOV_RST     = 24'h0009C4;
  // Overcurrent policy codes, two bits per channel
  localparam logic [1:0] POL_FAILSAFE = 2'h0;
  localparam logic [1:0] POL_AUTO     = 2'h1;
  localparam logic [1:0] POL_NONE     = 2'h2;
  typedef enum logic [2:0] {
    OC_OK  = 3'b001,
    OC_OFF = 3'b010,
    OC_HLD = 3'b100
  } sfrl_oc_t;
endpackage

// ===== sfrl_field_model.sv
// Purpose: field side model: supply, overcurrent sense, analog currents
// Assumes: bench commands; pins change just after the rising edge
// Notes:   all currents sit on one base so only the commanded delta differs
`timescale 1ns/1ps
module sfrl_field_model
  import sfrl_pkg::*;
(
  // Clock
  input  wire logic               sys_clk,
  // Commands from the bench
  input  wire logic               supply_off,
  input  wire logic [NUM_CH-1:0]  oc_cmd,
  input  wire logic [NUM_CH-1:0]  oc_keep,
  input  wire logic [CUR_W-1:0]   delta,
  // Field pins
  output logic                    field_supply_ok = 1'b1,
  output logic [NUM_CH-1:0]       overcurrent_in = '0,
  output logic [NUM_CH-1:0]       oc_present = '0,
  output logic [CUR_W-1:0]        ai_cur [NUM_AI]
);
  // -----------------------------------------
  // Field behaviour
  // -----------------------------------------
  localparam logic [CUR_W-1:0] BASE_CUR = 16'h2EE0;
  logic [CUR_W-1:0] delta_q = '0;
  always @(posedge sys_clk)
  begin
    field_supply_ok <= !supply_off;
    overcurrent_in  <= oc_cmd;
    oc_present      <= oc_keep;
    delta_q         <= delta;
  end
  // Channel 1 carries the offset, so a dual group also sees it
  always_comb
  begin
    ai_cur[0] = BASE_CUR;
    ai_cur[1] = BASE_CUR + delta_q;
    ai_cur[2] = BASE_CUR;
  end
endmodule

// ===== safety_fault_response_logic_tb.sv
// Purpose: self-checking bench for the fault response logic
// Assumes: 250 MHz clock, counts shortened through the registers
// Notes:   output latencies are loose, so waits are bounded polls
`timescale 1ns/1ps
module safety_fault_response_logic_tb
  import sfrl_pkg::*;
;
  logic                 sys_clk = 1'b0;
  logic                 rst = 1'b1;
  logic [7:0]           addr = 8'h00;
  logic [31:0]          wdata = 32'h0;
  logic                 wr = 1'b0;
  logic                 rd = 1'b0;
  logic [31:0]          rdata;
  logic                 supply_off = 1'b0;
  logic [NUM_CH-1:0]    oc_cmd = '0;
  logic [NUM_CH-1:0]    oc_keep = '0;
  logic [CUR_W-1:0]     delta = '0;
  logic                 ai_triple = 1'b1;
  logic                 field_supply_ok;
  logic [NUM_CH-1:0]    overcurrent_in;
  logic [NUM_CH-1:0]    oc_present;
  logic [CUR_W-1:0]     ai_cur [NUM_AI];
  logic [NUM_SIG-1:0]   simple_assign = '0;
  logic [NUM_SIG-1:0]   simple_value = '0;
  logic                 in_compound = 1'b0;
  logic                 compound_enter = 1'b0;
  logic [NUM_SIG-1:0]   sig_out;
  logic [NUM_CH-1:0]    channel_overload_fault;
  logic                 redundancy_mismatch_fault;
  logic                 redundancy_mismatch_warning;
  logic [NUM_FAULT-1:0] transition_faults;
  logic                 failsafe;
  logic [NUM_SIG-1:0]   def_top;
  logic [NUM_SIG-1:0]   def_cmp;
  int                   miscompares = 0;
  int                   num_checks = 0;

  always #2 sys_clk = ~sys_clk;

  sfrl_field_model i_field (.sys_clk(sys_clk), .supply_off(supply_off), .oc_cmd(oc_cmd),
    .oc_keep(oc_keep), .delta(delta), .field_supply_ok(field_supply_ok),
    .overcurrent_in(overcurrent_in), .oc_present(oc_present), .ai_cur(ai_cur));

  sfrl_top i_dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .field_supply_ok(field_supply_ok), .overcurrent_in(overcurrent_in),
    .oc_present(oc_present), .ai_cur(ai_cur), .ai_triple(ai_triple),
    .simple_assign(simple_assign), .simple_value(simple_value), .in_compound(in_compound),
    .compound_enter(compound_enter), .sig_out(sig_out),
    .channel_overload_fault(channel_overload_fault),
    .redundancy_mismatch_fault(redundancy_mismatch_fault),
    .redundancy_mismatch_warning(redundancy_mismatch_warning),
    .transition_faults(transition_faults), .failsafe(failsafe));

  // -----------------------------------------
  // Shared tasks and the reference model
  // -----------------------------------------
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = redundancy_mismatch_fault;
      1: pick = redundancy_mismatch_warning;
      2: pick = failsafe;
      default: pick = channel_overload_fault[sel-3];
    endcase
  endfunction

  // Polls are bounded; a hang ends the run as a failure
  task automatic wait_for(input int sel, input logic val, input int lim);
    int n;
    n = 0;
    while (pick(sel) !== val && n < lim)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("wait", 32'(val), 32'(pick(sel)));
    if (pick(sel) !== val)
      give_verdict();
  endtask

  task automatic hold_chk(input int sel, input logic val, input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      #1 chk("hold", 32'(val), 32'(pick(sel)));
    end
  endtask

  task automatic supply_cycle();
    @(posedge sys_clk);
    supply_off <= 1'b1;
    repeat (4) @(posedge sys_clk);
    supply_off <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  function automatic logic [31:0] exp_sig(input logic [NUM_SIG-1:0] dflt,
                                          input logic [NUM_CH-1:0] dead);
    logic [NUM_SIG-1:0] e;
    for (int i = 0; i < NUM_SIG; i++)
      e[i] = simple_assign[i] ? simple_value[i] : dflt[i];
    for (int i = 0; i < NUM_CH; i++)
      if (dead[i])
        e[i] = 1'b0;
    return 32'(e);
  endfunction

  // -----------------------------------------
  // Main sequence
  // -----------------------------------------
  initial
  begin
    void'($urandom(69087));
    def_top = {8'($urandom), 8'hFF};
    def_cmp = 16'($urandom);
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(REG_DISC_CUR, 32'(DISC_CUR_RST));
    rd_chk(REG_DISC_TIME, 32'(DISC_TIME_RST));
    rd_chk(REG_RECOV, 32'(RECOV_RST));
    rd_chk(8'h30, 32'h0);
    wr_reg(REG_DISC_CUR, 32'h5);
    wr_reg(REG_DISC_TIME, 32'd20);
    wr_reg(REG_RECOV, 32'd40);
    wr_reg(REG_POLICY, 32'h9);
    wr_reg(REG_FSSEL, 32'h0);
    wr_reg(REG_DEF_TOP, 32'(def_top));
    wr_reg(REG_DEF_CMP, 32'(def_cmp));
    simple_assign <= 16'($urandom);
    simple_value <= 16'($urandom);
    repeat (4) @(posedge sys_clk);
    #1 chk("sig_out stopped", 32'(def_top), 32'(sig_out));
    wr_reg(REG_CTRL, 32'h1);
    repeat (4) @(posedge sys_clk);
    #1 chk("sig_out top", exp_sig(def_top, '0), 32'(sig_out));
    @(posedge sys_clk);
    in_compound <= 1'b1;
    compound_enter <= 1'b1;
    @(posedge sys_clk);
    compound_enter <= 1'b0;
    simple_assign <= 16'($urandom);
    repeat (4) @(posedge sys_clk);
    #1 chk("sig_out compound", exp_sig(def_cmp, '0), 32'(sig_out));
    @(posedge sys_clk);
    in_compound <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 chk("sig_out left", exp_sig(def_top, '0), 32'(sig_out));
    $display("test defaults done");
    @(posedge sys_clk);
    delta <= 16'h000A;
    hold_chk(0, 1'b0, 20);
    wait_for(0, 1'b1, 30);
    @(posedge sys_clk);
    #1 chk("trans fault", 32'h1, 32'(transition_faults[8]));
    chk("failsafe", 32'h0, 32'(failsafe));
    @(posedge sys_clk);
    delta <= 16'h0;
    wait_for(0, 1'b0, 10);
    wr_reg(REG_CTRL, 32'h3);
    // Dual group from here on: only the first pair is compared
    ai_triple <= 1'b0;
    delta <= 16'h0005;
    hold_chk(1, 1'b0, 40);
    @(posedge sys_clk);
    delta <= 16'h000A;
    wait_for(1, 1'b1, 50);
    chk("fault in warn mode", 32'h0, 32'(redundancy_mismatch_fault));
    @(posedge sys_clk);
    delta <= 16'h0;
    wait_for(1, 1'b0, 10);
    wr_reg(REG_FSSEL, 32'h1 << FSSEL_WARN_BIT);
    delta <= 16'h000A;
    wait_for(2, 1'b1, 50);
    repeat (2) @(posedge sys_clk);
    #1 chk("trans warn", 32'h0, 32'(transition_faults[9]));
    chk("sig_out safe", 32'h0, 32'(sig_out[7:0]));
    rd_chk(REG_STATUS, 32'h1);
    @(posedge sys_clk);
    delta <= 16'h0;
    supply_cycle();
    wait_for(2, 1'b0, 20);
    wr_reg(REG_FSSEL, 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    $display("test mismatch done");
    oc_cmd <= 8'h01;
    repeat (3) @(posedge sys_clk);
    oc_cmd <= 8'h00;
    wait_for(3, 1'b1, 10);
    chk("sig_out dead", exp_sig(def_top, 8'h01), 32'(sig_out));
    hold_chk(3, 1'b1, 30);
    wait_for(3, 1'b0, 20);
    @(posedge sys_clk);
    oc_cmd <= 8'h01;
    oc_keep <= 8'h01;
    wait_for(3, 1'b1, 10);
    repeat (100) @(posedge sys_clk);
    #1 chk("fault repeat", 32'h1, 32'(channel_overload_fault[0]));
    @(posedge sys_clk);
    oc_cmd <= 8'h00;
    oc_keep <= 8'h00;
    wait_for(3, 1'b0, 60);
    $display("test auto recover done");
    wr_reg(REG_POLICY, 32'h0000AAAA);
    oc_cmd <= 8'hFF;
    repeat (3) @(posedge sys_clk);
    oc_cmd <= 8'h00;
    wait_for(10, 1'b1, 10);
    repeat (100) @(posedge sys_clk);
    #1 chk("all faults", 32'hFF, 32'(channel_overload_fault));
    chk("trans ch", 32'hFF, 32'(transition_faults[7:0]));
    chk("sig_out off", exp_sig(def_top, 8'hFF), 32'(sig_out));
    supply_cycle();
    wait_for(3, 1'b0, 20);
    $display("test no recover done");
    wr_reg(REG_POLICY, 32'h0);
    oc_cmd <= 8'h04;
    repeat (3) @(posedge sys_clk);
    oc_cmd <= 8'h00;
    wait_for(2, 1'b1, 12);
    repeat (50) @(posedge sys_clk);
    #1 chk("failsafe held", 32'h1, 32'(failsafe));
    chk("trans hidden", 32'h0, 32'(transition_faults[2]));
    chk("sig_out safe", 32'h0, 32'(sig_out[7:0]));
    supply_cycle();
    wait_for(2, 1'b0, 20);
    $display("test failsafe policy done");
    give_verdict();
  end
endmodule
